// file: design/pin_ctrl_pkg.sv
// Shared constants and carrier types for the port T / port S pin control block
// Functional notes
// - T drive bit 1 gives reduced drive
// - Drive select ignored while pin is input
// - Reduced drive applies to any pin owner
// - T pull enable bit turns pull on
// - Pull enable ignored on output pins
// - Polarity bit 1 pull-down, 0 pull-up
// - Reserved slot reads zero, ignores writes
// - Routing bits 5,4,0 pick T or P
// - S data read: register or pin by direction
// - GPIO output drives stored S data bit
// - Serial unit owns S pins 1 and 0
// - S input register returns synced pin states
// - Writes to S input register do nothing
// - S direction bit 1 output, 0 input
// - Serial unit forces direction, bits untouched
package pin_ctrl_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int T_PINS = 8;
   localparam int S_PINS = 4;
   localparam int PWM_CH = 3;

   // Byte addresses of the register map
   localparam logic [9:0] OFF_S_DATA = 10'h248;
   localparam logic [9:0] OFF_S_PIN_INPUT = 10'h24C;
   localparam logic [9:0] OFF_T_DRIVE_SELECT = 10'h250;
   localparam logic [9:0] OFF_T_PULL_ENABLE = 10'h254;
   localparam logic [9:0] OFF_T_PULL_POLARITY = 10'h258;
   localparam logic [9:0] OFF_RESERVED_SLOT = 10'h25C;
   localparam logic [9:0] OFF_T_PWM_ROUTING = 10'h260;
   localparam logic [9:0] OFF_S_DIRECTION = 10'h264;

   // Implemented bit masks
   localparam logic [7:0] S_MASK = 8'h0F;
   localparam logic [7:0] RR_MASK = 8'h31;
   localparam int RR_BIT_CH5 = 5;
   localparam int RR_BIT_CH4 = 4;
   localparam int RR_BIT_CH0 = 0;

   // Reset values
   localparam logic [7:0] RST_S_DATA = 8'h00;
   localparam logic [7:0] RST_S_DIRECTION = 8'h00;
   localparam logic [7:0] RST_T_DRIVE_SELECT = 8'h00;
   localparam logic [7:0] RST_T_PULL_ENABLE = 8'h00;
   localparam logic [7:0] RST_T_PULL_POLARITY = 8'h00;
   localparam logic [7:0] RST_T_PWM_ROUTING = 8'h00;
   localparam logic [7:0] RESERVED_VALUE = 8'h00;

   // Register port request from software
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Port T pad controls
   typedef struct packed {
      logic [7:0] reduced;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
   } t_pad_t;

   // PWM channel routing toward port T and port P pins (channels 5,4,0)
   typedef struct packed {
      logic [2:0] pt_out;
      logic [2:0] pt_en;
      logic [2:0] pp_out;
      logic [2:0] pp_en;
   } pwm_route_t;

endpackage : pin_ctrl_pkg

// file: design/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 4
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // The first stage feeds only the second stage
   always_comb begin
      st_nxt.meta = async_i;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stable;

   sync_delay_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      ##2 sync_o == $past(async_i, 2))
      else $error("pin synchroniser delay is not two cycles");
endmodule : pin_sync

// file: design/pwm_router.sv
// Steers each routable PWM channel to its port T pin or its port P pin
`timescale 1ns/1ps
module pwm_router #(
   parameter int N = 3
) (
   input wire logic [N-1:0] sel_t_i,
   input wire logic [N-1:0] pwm_i,
   input wire logic [N-1:0] pwm_en_i,
   output logic [N-1:0] pt_out_o,
   output logic [N-1:0] pt_en_o,
   output logic [N-1:0] pp_out_o,
   output logic [N-1:0] pp_en_o
);
   // Only the selected side sees the channel; the other side stays idle
   for (genvar i = 0; i < N; i++) begin : g_ch
      assign pt_out_o[i] = sel_t_i[i] & pwm_i[i];
      assign pt_en_o[i] = sel_t_i[i] & pwm_en_i[i];
      assign pp_out_o[i] = ~sel_t_i[i] & pwm_i[i];
      assign pp_en_o[i] = ~sel_t_i[i] & pwm_en_i[i];
   end
endmodule : pwm_router

// file: design/port_t_s_pin_control.sv
// Port T pad configuration, PWM routing and port S data/direction logic
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module port_t_s_pin_control (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Software register port
   input wire pin_ctrl_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   // Port T: which pins currently drive, from the port T data logic
   input wire logic [7:0] pt_out_act_i,
   output pin_ctrl_pkg::t_pad_t t_pad_o,
   // PWM channels 5,4,0 in bit order {5,4,0}
   input wire logic [2:0] pwm_i,
   input wire logic [2:0] pwm_en_i,
   output pin_ctrl_pkg::pwm_route_t pwm_route_o,
   // Port S pins
   input wire logic [3:0] ps_pin_i,
   output logic [3:0] ps_pin_o,
   output logic [3:0] ps_pin_oe_o,
   // Asynchronous serial unit
   input wire logic serial_tx_en_i,
   input wire logic serial_txd_i,
   input wire logic serial_rx_en_i,
   output logic serial_rxd_o
);
   typedef struct packed {
      logic [3:0] s_data;
      logic [3:0] s_dir;
      logic [7:0] t_rdr;
      logic [7:0] t_pe;
      logic [7:0] t_pps;
      logic [7:0] t_rr;
      logic [7:0] rdata;
   } regs_t;

   regs_t st_r;
   regs_t st_nxt;
   logic [3:0] ps_sync;
   logic [3:0] s_read;
   logic [2:0] rr_sel;

   // Address match used by both the write and the read decode
   function automatic logic hit(input logic [9:0] addr, input logic [9:0] off);
      hit = (addr == off);
   endfunction : hit

   // Pins come from outside the clock domain
   pin_sync #(
      .W(pin_ctrl_pkg::S_PINS)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .async_i(ps_pin_i),
      .sync_o(ps_sync)
   );

   // Data read source follows the stored direction bit
   assign s_read = (st_r.s_dir & st_r.s_data) | (~st_r.s_dir & ps_sync);

   // Register writes and registered read data
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;
      if (req_i.wr) begin
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_S_DATA)) begin
            st_nxt.s_data = req_i.wdata[3:0];
         end
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_S_DIRECTION)) begin
            st_nxt.s_dir = req_i.wdata[3:0];
         end
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_DRIVE_SELECT)) begin
            st_nxt.t_rdr = req_i.wdata;
         end
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_ENABLE)) begin
            st_nxt.t_pe = req_i.wdata;
         end
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_POLARITY)) begin
            st_nxt.t_pps = req_i.wdata;
         end
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PWM_ROUTING)) begin
            st_nxt.t_rr = req_i.wdata & pin_ctrl_pkg::RR_MASK;
         end
         // Input register and reserved slot have no write path
      end
      if (req_i.rd) begin
         if (hit(req_i.addr, pin_ctrl_pkg::OFF_S_DATA)) begin
            st_nxt.rdata = {4'h0, s_read};
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_S_PIN_INPUT)) begin
            st_nxt.rdata = {4'h0, ps_sync};
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_S_DIRECTION)) begin
            st_nxt.rdata = {4'h0, st_r.s_dir};
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_DRIVE_SELECT)) begin
            st_nxt.rdata = st_r.t_rdr;
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_ENABLE)) begin
            st_nxt.rdata = st_r.t_pe;
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_POLARITY)) begin
            st_nxt.rdata = st_r.t_pps;
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_T_PWM_ROUTING)) begin
            st_nxt.rdata = st_r.t_rr;
         end else if (hit(req_i.addr, pin_ctrl_pkg::OFF_RESERVED_SLOT)) begin
            st_nxt.rdata = pin_ctrl_pkg::RESERVED_VALUE;
         end
      end
   end

   // Whole state in one register; unmapped reads return zero
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r.s_data <= pin_ctrl_pkg::RST_S_DATA[3:0];
         st_r.s_dir <= pin_ctrl_pkg::RST_S_DIRECTION[3:0];
         st_r.t_rdr <= pin_ctrl_pkg::RST_T_DRIVE_SELECT;
         st_r.t_pe <= pin_ctrl_pkg::RST_T_PULL_ENABLE;
         st_r.t_pps <= pin_ctrl_pkg::RST_T_PULL_POLARITY;
         st_r.t_rr <= pin_ctrl_pkg::RST_T_PWM_ROUTING;
         st_r.rdata <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o = st_r.rdata;

   // Reduced drive follows output activity, whoever owns the pin
   assign t_pad_o.reduced = st_r.t_rdr & pt_out_act_i;
   // Pulls only act on pins that are not driving
   assign t_pad_o.pull_up = st_r.t_pe & ~pt_out_act_i & ~st_r.t_pps;
   assign t_pad_o.pull_down = st_r.t_pe & ~pt_out_act_i & st_r.t_pps;

   // Routing select in channel order {5,4,0}
   assign rr_sel = {st_r.t_rr[pin_ctrl_pkg::RR_BIT_CH5],
                    st_r.t_rr[pin_ctrl_pkg::RR_BIT_CH4],
                    st_r.t_rr[pin_ctrl_pkg::RR_BIT_CH0]};

   pwm_router #(
      .N(pin_ctrl_pkg::PWM_CH)
   ) u_router (
      .sel_t_i(rr_sel),
      .pwm_i(pwm_i),
      .pwm_en_i(pwm_en_i),
      .pt_out_o(pwm_route_o.pt_out),
      .pt_en_o(pwm_route_o.pt_en),
      .pp_out_o(pwm_route_o.pp_out),
      .pp_en_o(pwm_route_o.pp_en)
   );

   // Port S pads: serial unit overrides GPIO without touching stored bits
   always_comb begin
      ps_pin_oe_o = st_r.s_dir;
      ps_pin_o = st_r.s_data & st_r.s_dir;
      if (serial_tx_en_i) begin
         ps_pin_oe_o[1] = 1'b1;
         ps_pin_o[1] = serial_txd_i;
      end
      if (serial_rx_en_i) begin
         ps_pin_oe_o[0] = 1'b0;
         ps_pin_o[0] = 1'b0;
      end
   end

   // Receiver sees the synchronised pin; it is idle-high when unused
   assign serial_rxd_o = serial_rx_en_i ? ps_sync[0] : 1'b1;

   // Checks run on the one core clock and sleep through reset
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   drive_write_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_DRIVE_SELECT)
      |=> t_pad_o.reduced == ($past(req_i.wdata) & pt_out_act_i))
      else $error("reduced drive does not follow written select");

   drive_input_a: assert property (
      (t_pad_o.reduced & ~pt_out_act_i) == 8'h00)
      else $error("reduced drive active on input pin");

   pull_output_a: assert property (
      ((t_pad_o.pull_up | t_pad_o.pull_down) & pt_out_act_i) == 8'h00)
      else $error("pull device active on output pin");

   pull_pol_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_POLARITY)
      |=> t_pad_o.pull_down == ($past(req_i.wdata) & st_r.t_pe & ~pt_out_act_i))
      else $error("pull-down does not follow polarity write");

   pull_enable_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_ENABLE)
      |=> (t_pad_o.pull_up | t_pad_o.pull_down) == ($past(req_i.wdata) & ~pt_out_act_i))
      else $error("pull devices do not follow enable write");

   rsvd_read_a: assert property (
      req_i.rd && hit(req_i.addr, pin_ctrl_pkg::OFF_RESERVED_SLOT) |=> rdata_o == 8'h00)
      else $error("reserved slot read is not zero");

   route_sel_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PWM_ROUTING)
      |=> pwm_route_o.pt_en == ({$past(req_i.wdata[5]), $past(req_i.wdata[4]),
          $past(req_i.wdata[0])} & pwm_en_i))
      else $error("PWM routing does not follow written bits");

   s_read_a: assert property (
      req_i.rd && hit(req_i.addr, pin_ctrl_pkg::OFF_S_DATA)
      |=> rdata_o == {4'h0, ($past(st_r.s_dir) & $past(st_r.s_data))
          | (~$past(st_r.s_dir) & $past(ps_sync))})
      else $error("port S data read uses wrong source");

   s_drive_a: assert property (
      st_r.s_dir[3] |-> ps_pin_oe_o[3] && ps_pin_o[3] == st_r.s_data[3])
      else $error("GPIO output does not drive stored bit");

   serial_own_a: assert property (
      serial_tx_en_i |-> ps_pin_oe_o[1] && ps_pin_o[1] == serial_txd_i)
      else $error("serial transmit does not own pin 1");

   serial_dir_a: assert property (
      serial_rx_en_i && !req_i.wr ##1 serial_rx_en_i |-> !ps_pin_oe_o[0] && $stable(st_r.s_dir))
      else $error("serial receive direction override wrong");

   pin_read_a: assert property (
      req_i.rd && hit(req_i.addr, pin_ctrl_pkg::OFF_S_PIN_INPUT)
      |=> rdata_o == {4'h0, $past(ps_sync)})
      else $error("input register read is not pin state");

   pin_wr_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_S_PIN_INPUT)
      |=> st_r.s_data == $past(st_r.s_data) && st_r.t_rr == $past(st_r.t_rr))
      else $error("write to input register changed state");

   s_dir_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_S_DIRECTION) && !serial_tx_en_i
      |=> ps_pin_oe_o[3:1] == $past(req_i.wdata[3:1]))
      else $error("direction write does not set pad enable");

   unimpl_a: assert property (
      req_i.rd && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PWM_ROUTING)
      |=> (rdata_o & ~pin_ctrl_pkg::RR_MASK) == 8'h00)
      else $error("unimplemented routing bits read nonzero");

   // Read data stand for one cycle only, so a late sampler sees zero
   rdata_idle_a: assert property (
      !req_i.rd |=> rdata_o == 8'h00)
      else $error("read data not cleared after read cycle");

   drive_full_a: assert property (
      (t_pad_o.reduced & ~st_r.t_rdr) == 8'h00)
      else $error("reduced drive without select bit");

   // Owner of a pin is not known here, only that it drives
   drive_owner_a: assert property (
      pt_out_act_i == 8'hFF |-> t_pad_o.reduced == st_r.t_rdr)
      else $error("reduced drive depends on pin owner");

   pull_excl_a: assert property (
      (t_pad_o.pull_up & t_pad_o.pull_down) == 8'h00)
      else $error("pull-up and pull-down both on");

   pull_up_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PULL_POLARITY)
      |=> t_pad_o.pull_up == (~$past(req_i.wdata) & st_r.t_pe & ~pt_out_act_i))
      else $error("pull-up does not follow polarity write");

   rsvd_write_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_RESERVED_SLOT)
      |=> $stable({st_r.s_data, st_r.s_dir, st_r.t_rdr, st_r.t_pe, st_r.t_pps, st_r.t_rr}))
      else $error("write to reserved slot changed state");

   route_pp_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_T_PWM_ROUTING)
      |=> pwm_route_o.pp_en == (~{$past(req_i.wdata[5]), $past(req_i.wdata[4]),
          $past(req_i.wdata[0])} & pwm_en_i))
      else $error("PWM channel not returned to port P pin");

   tx_gpio_a: assert property (
      !serial_tx_en_i && st_r.s_dir[1] |-> ps_pin_oe_o[1] && ps_pin_o[1] == st_r.s_data[1])
      else $error("GPIO output pin 1 does not drive stored bit");

   rx_idle_a: assert property (
      !serial_rx_en_i |-> serial_rxd_o)
      else $error("receive line not idle while receiver off");

   rx_follow_a: assert property (
      serial_rx_en_i |-> serial_rxd_o == ps_sync[0] && !ps_pin_oe_o[0])
      else $error("receiver does not see pin 0");

   s_input_a: assert property (
      !serial_tx_en_i && !serial_rx_en_i |-> ps_pin_oe_o == st_r.s_dir)
      else $error("pad enable does not follow direction bits");

   dir_store_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_S_DIRECTION)
      |=> st_r.s_dir == $past(req_i.wdata[3:0]))
      else $error("direction write not stored under serial override");

   s_write_a: assert property (
      req_i.wr && hit(req_i.addr, pin_ctrl_pkg::OFF_S_DATA)
      |=> st_r.s_data == $past(req_i.wdata[3:0]))
      else $error("port S data write not stored");

   rr_mask_a: assert property (
      (st_r.t_rr & ~pin_ctrl_pkg::RR_MASK) == 8'h00)
      else $error("unimplemented routing bits hold ones");

   cov_s_read: cover property (req_i.rd && hit(req_i.addr, pin_ctrl_pkg::OFF_S_DATA));
   cov_route_t: cover property (|pwm_route_o.pt_en);
   cov_serial: cover property (serial_tx_en_i && serial_rx_en_i);
   cov_pull_down: cover property (|t_pad_o.pull_down);
   cov_route_p: cover property (|pwm_route_o.pp_en);

endmodule : port_t_s_pin_control

// file: test/ps_pad_model.sv
// Board-side model of the four port S pads
`timescale 1ns/1ps
module ps_pad_model (
   input wire logic [3:0] drv_i,
   input wire logic [3:0] oe_i,
   input wire logic [3:0] ext_i,
   output logic [3:0] level_o
);
   // A driving pad wins over the board driver; otherwise the board level shows
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level_o[i] = oe_i[i] ? drv_i[i] : ext_i[i];
      end
   end
endmodule : ps_pad_model

// file: test/testbench.sv
// Self-checking bench for the port T / port S pin control block
`timescale 1ns/1ps
module testbench;
   logic core_clk_i;
   logic resetn_i;
   pin_ctrl_pkg::reg_req_t req;
   pin_ctrl_pkg::t_pad_t pad;
   pin_ctrl_pkg::pwm_route_t rt;
   logic [7:0] rdata;
   logic [7:0] pt_act;
   logic [2:0] pwm;
   logic [2:0] pwm_en;
   logic [3:0] ps_in;
   logic [3:0] ps_out;
   logic [3:0] ps_oe;
   logic [3:0] ext;
   logic tx_en;
   logic txd;
   logic rx_en;
   logic rxd;
   logic [2:0] s;
   int err_total;
   int checks_done;
   logic [9:0] offs [8];

   port_t_s_pin_control u_port_t_s_pin_control (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .req_i(req), .rdata_o(rdata), .pt_out_act_i(pt_act), .t_pad_o(pad), .pwm_i(pwm),
      .pwm_en_i(pwm_en), .pwm_route_o(rt), .ps_pin_i(ps_in), .ps_pin_o(ps_out),
      .ps_pin_oe_o(ps_oe), .serial_tx_en_i(tx_en), .serial_txd_i(txd),
      .serial_rx_en_i(rx_en), .serial_rxd_o(rxd));
   ps_pad_model u_ps_pad_model (.drv_i(ps_out), .oe_i(ps_oe), .ext_i(ext), .level_o(ps_in));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Verdict and end of run, shared by the main sequence and the watchdog
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One-cycle write strobe, released at the next edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge core_clk_i);
      req.wr <= 1'b0;
   endtask : wr

   // Read data is sampled in the single cycle after the strobe
   task automatic rdchk(input string n, input logic [9:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk_i);
      req.rd <= 1'b0;
      #1;
      chk(n, e, rdata);
   endtask : rdchk

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_total++;
      complete_run();
   end

   initial begin
      req = '0;
      pt_act = 8'h00;
      pwm = 3'h0;
      pwm_en = 3'h0;
      ext = 4'h0;
      tx_en = 1'b0;
      txd = 1'b1;
      rx_en = 1'b0;
      err_total = 0;
      checks_done = 0;
      resetn_i = 1'b0;
      offs = '{pin_ctrl_pkg::OFF_S_DATA, pin_ctrl_pkg::OFF_S_PIN_INPUT,
               pin_ctrl_pkg::OFF_T_DRIVE_SELECT, pin_ctrl_pkg::OFF_T_PULL_ENABLE,
               pin_ctrl_pkg::OFF_T_PULL_POLARITY, pin_ctrl_pkg::OFF_RESERVED_SLOT,
               pin_ctrl_pkg::OFF_T_PWM_ROUTING, pin_ctrl_pkg::OFF_S_DIRECTION};
      repeat (12) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      // Reset values of every register slot
      foreach (offs[i]) rdchk("reset", offs[i], 8'h00);
      chk("rxd idle", 8'h01, {7'h00, rxd});
      chk("reset oe", 8'h00, {4'h0, ps_oe});
      // Port T pad controls, mixed pin activity
      wr(pin_ctrl_pkg::OFF_T_DRIVE_SELECT, 8'hA5);
      wr(pin_ctrl_pkg::OFF_T_PULL_ENABLE, 8'h3C);
      wr(pin_ctrl_pkg::OFF_T_PULL_POLARITY, 8'hF0);
      rdchk("drive", pin_ctrl_pkg::OFF_T_DRIVE_SELECT, 8'hA5);
      rdchk("pull_en", pin_ctrl_pkg::OFF_T_PULL_ENABLE, 8'h3C);
      rdchk("polarity", pin_ctrl_pkg::OFF_T_PULL_POLARITY, 8'hF0);
      @(posedge core_clk_i);
      pt_act <= 8'h0F;
      @(posedge core_clk_i);
      #1;
      chk("reduced", 8'h05, pad.reduced);
      chk("pull_up", 8'h00, pad.pull_up);
      chk("pull_down", 8'h30, pad.pull_down);
      // Pins 7, 6, 1 and 0 driving, so pull-ups must show
      @(posedge core_clk_i);
      pt_act <= 8'hC3;
      @(posedge core_clk_i);
      #1;
      chk("reduced", 8'h81, pad.reduced);
      chk("pull_up", 8'h0C, pad.pull_up);
      chk("pull_down", 8'h30, pad.pull_down);
      // Every routing combination of channels 5, 4 and 0
      @(posedge core_clk_i);
      pwm <= 3'b101;
      pwm_en <= 3'b111;
      for (int k = 0; k < 8; k++) begin
         s = 3'(k);
         wr(pin_ctrl_pkg::OFF_T_PWM_ROUTING, {2'b00, s[2], s[1], 3'b000, s[0]});
         #1;
         chk("pt_en", {5'h00, s}, {5'h00, rt.pt_en});
         chk("pp_en", {5'h00, ~s}, {5'h00, rt.pp_en});
         chk("pt_out", {5'h00, s & 3'b101}, {5'h00, rt.pt_out});
         chk("pp_out", {5'h00, ~s & 3'b101}, {5'h00, rt.pp_out});
      end
      wr(pin_ctrl_pkg::OFF_T_PWM_ROUTING, 8'hFF);
      rdchk("routing", pin_ctrl_pkg::OFF_T_PWM_ROUTING, 8'h31);
      @(posedge core_clk_i);
      #1;
      chk("rdata idle", 8'h00, rdata);
      // Reserved slot and an unmapped address take no write
      wr(pin_ctrl_pkg::OFF_RESERVED_SLOT, 8'hFF);
      rdchk("reserved", pin_ctrl_pkg::OFF_RESERVED_SLOT, 8'h00);
      wr(10'h2FE, 8'hFF);
      rdchk("unmapped", 10'h2FE, 8'h00);
      // Port S: pins 0 and 2 outputs, 1 and 3 driven by the board
      @(posedge core_clk_i);
      ext <= 4'hA;
      wr(pin_ctrl_pkg::OFF_S_DIRECTION, 8'h05);
      wr(pin_ctrl_pkg::OFF_S_DATA, 8'hF3);
      #1;
      chk("s_oe", 8'h05, {4'h0, ps_oe});
      chk("s_out", 8'h01, {4'h0, ps_out & ps_oe});
      repeat (3) @(posedge core_clk_i);
      rdchk("s_data", pin_ctrl_pkg::OFF_S_DATA, 8'h0B);
      rdchk("s_input", pin_ctrl_pkg::OFF_S_PIN_INPUT, 8'h0B);
      wr(pin_ctrl_pkg::OFF_S_PIN_INPUT, 8'hFF);
      rdchk("s_data", pin_ctrl_pkg::OFF_S_DATA, 8'h0B);
      rdchk("s_dir", pin_ctrl_pkg::OFF_S_DIRECTION, 8'h05);
      // Serial unit takes pins 1 and 0 over all-output GPIO
      wr(pin_ctrl_pkg::OFF_S_DIRECTION, 8'h0F);
      ext <= 4'h1;
      tx_en <= 1'b1;
      txd <= 1'b0;
      rx_en <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("ser_oe", 8'h0E, {4'h0, ps_oe});
      chk("ser_tx", 8'h00, {7'h00, ps_out[1]});
      chk("ser_rx", 8'h01, {7'h00, rxd});
      @(posedge core_clk_i);
      ext <= 4'h0;
      txd <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("ser_rx", 8'h00, {7'h00, rxd});
      chk("ser_tx", 8'h01, {7'h00, ps_out[1]});
      rdchk("s_dir", pin_ctrl_pkg::OFF_S_DIRECTION, 8'h0F);
      @(posedge core_clk_i);
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk("gpio_oe", 8'h0F, {4'h0, ps_oe});
      chk("gpio_out", 8'h03, {4'h0, ps_out});
      complete_run();
   end
endmodule : testbench
